// ==== hw/gpt_pkg.sv ====
package gpt_pkg;

   // ----------------------------------------------------------------------
   // Register byte offsets
   // ----------------------------------------------------------------------
   localparam logic [11:0] OFS_CONFIG = 12'h000;
   localparam logic [11:0] OFS_MODE_A = 12'h004;
   localparam logic [11:0] OFS_MODE_B = 12'h008;
   localparam logic [11:0] OFS_CONTROL = 12'h00C;
   localparam logic [11:0] OFS_INT_MASK = 12'h018;
   localparam logic [11:0] OFS_RAW_STAT = 12'h01C;
   localparam logic [11:0] OFS_MASK_STAT = 12'h020;
   localparam logic [11:0] OFS_INT_CLEAR = 12'h024;
   localparam logic [11:0] OFS_LOAD_A = 12'h028;
   localparam logic [11:0] OFS_LOAD_B = 12'h02C;
   localparam logic [11:0] OFS_MATCH_A = 12'h030;
   localparam logic [11:0] OFS_PRESC_A = 12'h038;
   localparam logic [11:0] OFS_PRESC_B = 12'h03C;
   localparam logic [11:0] OFS_COUNT_A = 12'h048;
   localparam logic [11:0] OFS_COUNT_B = 12'h04C;

   // ----------------------------------------------------------------------
   // Configuration values
   // ----------------------------------------------------------------------
   localparam logic [2:0] CFG_32_TIMER = 3'h0;
   localparam logic [2:0] CFG_32_RTC = 3'h1;
   localparam logic [2:0] CFG_16_SPLIT = 3'h4;

   // ----------------------------------------------------------------------
   // Mode field values
   // ----------------------------------------------------------------------
   localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
   localparam logic [1:0] MODE_PERIODIC = 2'h2;

   // ----------------------------------------------------------------------
   // Control bit positions
   // ----------------------------------------------------------------------
   localparam int CTL_EN_A = 0;
   localparam int CTL_STALL_A = 1;
   localparam int CTL_RTC_EN = 4;
   localparam int CTL_EN_B = 8;
   localparam int CTL_STALL_B = 9;

   // ----------------------------------------------------------------------
   // Interrupt bit positions
   // ----------------------------------------------------------------------
   localparam int INT_TO_A = 0;
   localparam int INT_RTC = 3;
   localparam int INT_TO_B = 8;

   // ----------------------------------------------------------------------
   // Reset values and constants
   // ----------------------------------------------------------------------
   localparam logic [15:0] RST_HALF = 16'hFFFF;
   localparam logic [7:0] RST_PRESC = 8'h00;
   localparam logic [31:0] RTC_FIRST = 32'h0000_0001;
   localparam logic [31:0] ZERO32 = 32'h0000_0000;
   localparam logic [15:0] ZERO16 = 16'h0000;
   localparam logic [14:0] RTC_DIV_LAST = 15'h7FFF;

   // AHB-Lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage : gpt_pkg

// ==== hw/gpt_timer.sv ====
// Operation
// RULE1 - Config 0 selects 32-bit timer, 1 selects 32-bit RTC; halves join.
// RULE2 - Config 4 splits the block into two independent 16-bit timers.
// RULE3 - 32-bit config acts as one timer; 16-bit halves run independently.
// RULE4 - After reset timer inactive and control registers at defaults.
// RULE5 - Reset sets both counters and both load registers to FFFF.
// RULE6 - Reset sets both prescale registers to zero.
// RULE7 - In 32-bit modes load A write fills B with upper, A with lower.
// RULE8 - In 32-bit modes count A read returns B count high, A low.
// RULE9 - 32-bit one-shot or periodic is chosen by mode A only.
// RULE10 - Enable A counts 32-bit down; after zero reloads joined load value.
// RULE11 - One-shot stops at zero clearing enable A; periodic keeps going.
// RULE12 - Zero sets raw time-out flag and trigger; held until clear write.
// RULE13 - Masked time-out flag set when raw flag and mask bit both set.
// RULE14 - Load write while running is taken next cycle, counting continues.
// RULE15 - Stall A set holds the counter during debug halt, resume after.
// RULE16 - RTC counts up; first time selected the counter loads 1.
// RULE17 - Software gives later RTC load or compare values via match A.
// RULE18 - External 32.768 KHz on even capture pin divided to 1 Hz tick.
// RULE19 - RTC equal to match rolls to zero and keeps counting until disabled.
// RULE20 - RTC match sets raw flag; with mask sets masked flag and interrupt.
// RULE21 - Writing RTC clear bit clears raw and masked RTC flags.
// RULE22 - RTC stall override keeps RTC counting during halt despite stalls.
// RULE23 - External clock is synchronised and edge detected before divider.
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
module gpt_timer
   import gpt_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Pins and debug
   input wire logic capture_pin_even_zero,
   input wire logic debug_halt,
   // Events
   output logic timeout_trigger,
   output logic timer_irq
);

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [2:0] cfg_q;
   logic [1:0] mode_a_q, mode_b_q;
   logic en_a_q, en_b_q, stall_a_q, stall_b_q, rtc_en_q;
   logic [15:0] load_a_q, load_b_q, cnt_a_q, cnt_b_q;
   logic [7:0] presc_a_q, presc_b_q, pcnt_a_q, pcnt_b_q;
   logic [31:0] match_q;
   logic [8:0] mask_q;
   logic to_a_q, to_b_q, rtc_q;
   logic rtc_seen_q;
   logic reload_a_q, reload_b_q;
   logic trig_q;

   // Bus phase
   logic wr_q;
   logic [11:0] addr_q;
   logic [31:0] rdata_q;

   function automatic logic halted(input logic stall);
      halted = stall && debug_halt;
   endfunction : halted

   // ----------------------------------------------------------------------
   // AHB address phase
   // ----------------------------------------------------------------------
   wire logic take = hsel && hready && (htrans == HTRANS_NONSEQ);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         addr_q <= 12'h000;
      end else begin
         wr_q <= take && hwrite && (hsize == HSIZE_WORD);
         addr_q <= haddr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   wire logic is32 = (cfg_q == CFG_32_TIMER) || (cfg_q == CFG_32_RTC); // [RULE1] [RULE3]
   wire logic split = (cfg_q == CFG_16_SPLIT); // [RULE2]
   wire logic rtc_mode = (cfg_q == CFG_32_RTC);
   wire logic wr_cfg = wr_q && (addr_q == OFS_CONFIG);
   wire logic wr_ctl = wr_q && (addr_q == OFS_CONTROL);
   wire logic wr_lda = wr_q && (addr_q == OFS_LOAD_A);
   wire logic wr_ldb = wr_q && (addr_q == OFS_LOAD_B) && split;
   wire logic wr_icr = wr_q && (addr_q == OFS_INT_CLEAR);
   wire logic wr_mat = wr_q && (addr_q == OFS_MATCH_A);

   // ----------------------------------------------------------------------
   // RTC clock input and 1 Hz divider
   // ----------------------------------------------------------------------
   logic ext_s1_q, ext_s2_q, ext_s3_q;
   logic [14:0] div_q;
   logic sec_tick;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else begin
         ext_s1_q <= capture_pin_even_zero; // [RULE23]
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   wire logic ext_rise = ext_s2_q && !ext_s3_q; // [RULE23]

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_q <= 15'h0000;
      end else if (!(rtc_mode && en_a_q)) begin
         div_q <= 15'h0000;
      end else if (ext_rise) begin
         div_q <= (div_q == RTC_DIV_LAST) ? 15'h0000 : div_q + 15'h0001; // [RULE18]
      end
   end

   assign sec_tick = ext_rise && (div_q == RTC_DIV_LAST); // [RULE18]

   // ----------------------------------------------------------------------
   // Configuration, mode, match, mask, prescale
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= CFG_32_TIMER; // [RULE4]
         mode_a_q <= 2'h0;
         mode_b_q <= 2'h0;
         match_q <= 32'hFFFF_FFFF;
         mask_q <= 9'h000;
         presc_a_q <= RST_PRESC; // [RULE6]
         presc_b_q <= RST_PRESC; // [RULE6]
      end else if (wr_q) begin
         case (addr_q)
            OFS_CONFIG: cfg_q <= hwdata[2:0];
            OFS_MODE_A: mode_a_q <= hwdata[1:0];
            OFS_MODE_B: mode_b_q <= hwdata[1:0];
            OFS_MATCH_A: match_q <= is32 ? hwdata : {16'h0000, hwdata[15:0]}; // [RULE17]
            OFS_INT_MASK: mask_q <= hwdata[8:0];
            OFS_PRESC_A: presc_a_q <= hwdata[7:0];
            OFS_PRESC_B: presc_b_q <= hwdata[7:0];
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------------
   logic done_a, done_b;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_a_q <= 1'b0; // [RULE4]
         en_b_q <= 1'b0;
         stall_a_q <= 1'b0;
         stall_b_q <= 1'b0;
         rtc_en_q <= 1'b0;
      end else if (wr_ctl) begin
         en_a_q <= hwdata[CTL_EN_A];
         en_b_q <= hwdata[CTL_EN_B];
         stall_a_q <= hwdata[CTL_STALL_A];
         stall_b_q <= hwdata[CTL_STALL_B];
         rtc_en_q <= hwdata[CTL_RTC_EN];
      end else begin
         if (done_a) begin
            en_a_q <= 1'b0; // [RULE11]
         end
         if (done_b) begin
            en_b_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Load registers
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         load_a_q <= RST_HALF; // [RULE5]
         load_b_q <= RST_HALF; // [RULE5]
         reload_a_q <= 1'b0;
         reload_b_q <= 1'b0;
      end else begin
         reload_a_q <= wr_lda; // [RULE14]
         reload_b_q <= wr_ldb;
         if (wr_lda) begin
            load_a_q <= hwdata[15:0];
            if (is32) begin
               load_b_q <= hwdata[31:16]; // [RULE7]
            end
         end
         if (wr_ldb) begin
            load_b_q <= hwdata[15:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Counters
   // ----------------------------------------------------------------------
   wire logic [31:0] cnt32 = {cnt_b_q, cnt_a_q};
   wire logic zero32 = (cnt32 == ZERO32);
   wire logic run32 = is32 && !rtc_mode && en_a_q && !halted(stall_a_q); // [RULE15]
   wire logic run_rtc = rtc_mode && en_a_q && (rtc_en_q || !(halted(stall_a_q) ||
      halted(stall_b_q))); // [RULE22]
   wire logic run_a16 = split && en_a_q && !halted(stall_a_q) && (pcnt_a_q == 8'h00);
   wire logic run_b16 = split && en_b_q && !halted(stall_b_q) && (pcnt_b_q == 8'h00);
   wire logic hit32 = run32 && zero32;
   wire logic hit_a16 = run_a16 && (cnt_a_q == ZERO16);
   wire logic hit_b16 = run_b16 && (cnt_b_q == ZERO16);
   wire logic rtc_hit = run_rtc && sec_tick && (cnt32 == match_q); // [RULE19]

   assign done_a = (hit32 && (mode_a_q == MODE_ONE_SHOT)) || // [RULE9] [RULE11]
      (hit_a16 && (mode_a_q == MODE_ONE_SHOT));
   assign done_b = hit_b16 && (mode_b_q == MODE_ONE_SHOT);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rtc_seen_q <= 1'b0;
      end else if (wr_cfg && (hwdata[2:0] == CFG_32_RTC)) begin
         rtc_seen_q <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_a_q <= RST_HALF; // [RULE5]
         cnt_b_q <= RST_HALF; // [RULE5]
      end else if (wr_cfg && (hwdata[2:0] == CFG_32_RTC) && !rtc_seen_q) begin
         {cnt_b_q, cnt_a_q} <= RTC_FIRST; // [RULE16]
      end else if (rtc_mode) begin
         if (wr_mat) begin
            {cnt_b_q, cnt_a_q} <= hwdata; // [RULE17]
         end else if (rtc_hit) begin
            {cnt_b_q, cnt_a_q} <= ZERO32; // [RULE19]
         end else if (run_rtc && sec_tick) begin
            {cnt_b_q, cnt_a_q} <= cnt32 + 32'h0000_0001; // [RULE16]
         end
      end else if (is32) begin
         if (reload_a_q || hit32) begin
            {cnt_b_q, cnt_a_q} <= {load_b_q, load_a_q}; // [RULE10] [RULE14]
         end else if (run32) begin
            {cnt_b_q, cnt_a_q} <= cnt32 - 32'h0000_0001; // [RULE10]
         end
      end else begin
         if (reload_a_q || hit_a16) begin
            cnt_a_q <= load_a_q;
         end else if (run_a16) begin
            cnt_a_q <= cnt_a_q - 16'h0001;
         end
         if (reload_b_q || hit_b16) begin
            cnt_b_q <= load_b_q;
         end else if (run_b16) begin
            cnt_b_q <= cnt_b_q - 16'h0001;
         end
      end
   end

   // Prescalers extend each half in split one-shot or periodic use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pcnt_a_q <= RST_PRESC;
         pcnt_b_q <= RST_PRESC;
      end else begin
         if (split && en_a_q && !halted(stall_a_q)) begin
            pcnt_a_q <= (pcnt_a_q == 8'h00) ? presc_a_q : pcnt_a_q - 8'h01;
         end
         if (split && en_b_q && !halted(stall_b_q)) begin
            pcnt_b_q <= (pcnt_b_q == 8'h00) ? presc_b_q : pcnt_b_q - 8'h01;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Status flags; a new event wins over a clear
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         to_a_q <= 1'b0;
         to_b_q <= 1'b0;
         rtc_q <= 1'b0;
         trig_q <= 1'b0;
      end else begin
         trig_q <= hit32 || hit_a16; // [RULE12]
         if (hit32 || hit_a16) begin
            to_a_q <= 1'b1; // [RULE12]
         end else if (wr_icr && hwdata[INT_TO_A]) begin
            to_a_q <= 1'b0; // [RULE12]
         end
         if (hit_b16) begin
            to_b_q <= 1'b1;
         end else if (wr_icr && hwdata[INT_TO_B]) begin
            to_b_q <= 1'b0;
         end
         if (rtc_hit) begin
            rtc_q <= 1'b1; // [RULE20]
         end else if (wr_icr && hwdata[INT_RTC]) begin
            rtc_q <= 1'b0; // [RULE21]
         end
      end
   end

   wire logic [8:0] raw_stat = {to_b_q, 4'h0, rtc_q, 2'h0, to_a_q};
   wire logic [8:0] mis_stat = raw_stat & mask_q; // [RULE13] [RULE20] [RULE21]

   assign timeout_trigger = trig_q;
   assign timer_irq = |mis_stat; // [RULE20]

   // ----------------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= ZERO32;
      end else if (take && !hwrite) begin
         case (haddr)
            OFS_CONFIG: rdata_q <= {29'h0, cfg_q};
            OFS_MODE_A: rdata_q <= {30'h0, mode_a_q};
            OFS_MODE_B: rdata_q <= {30'h0, mode_b_q};
            OFS_CONTROL: rdata_q <= {22'h0, stall_b_q, en_b_q, 3'h0, rtc_en_q, 2'h0,
               stall_a_q, en_a_q};
            OFS_INT_MASK: rdata_q <= {23'h0, mask_q};
            OFS_RAW_STAT: rdata_q <= {23'h0, raw_stat};
            OFS_MASK_STAT: rdata_q <= {23'h0, mis_stat};
            OFS_LOAD_A: rdata_q <= is32 ? {load_b_q, load_a_q} : {16'h0, load_a_q};
            OFS_LOAD_B: rdata_q <= {16'h0, load_b_q};
            OFS_MATCH_A: rdata_q <= match_q;
            OFS_PRESC_A: rdata_q <= {24'h0, presc_a_q};
            OFS_PRESC_B: rdata_q <= {24'h0, presc_b_q};
            OFS_COUNT_A: rdata_q <= is32 ? cnt32 : {16'h0, cnt_a_q}; // [RULE8]
            OFS_COUNT_B: rdata_q <= {16'h0, cnt_b_q};
            default: rdata_q <= ZERO32;
         endcase
      end
   end

   assign hrdata = rdata_q;

endmodule : gpt_timer

// ==== test/gpt_timer_checker.sv ====
module gpt_timer_checker
   import gpt_pkg::*;
(
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Bus
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   // Pins and events
   input wire logic capture_pin_even_zero,
   input wire logic debug_halt,
   input wire logic timeout_trigger,
   input wire logic timer_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------------------------------------
   // Shadow of software writes
   // ----------------------------------------------------------------------
   logic wr_pend_q;
   logic [11:0] wr_addr_q;
   logic [31:0] cfg_q;
   logic [31:0] ctl_q;
   logic [31:0] msk_q;
   logic taken;
   logic rd_take;
   logic en_a;
   assign taken = hsel && hready && htrans == HTRANS_NONSEQ;
   assign rd_take = taken && !hwrite;
   assign en_a = ctl_q[CTL_EN_A];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= taken && hwrite && hsize == HSIZE_WORD;
         wr_addr_q <= haddr;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_q <= 32'h0000_0000;
         ctl_q <= 32'h0000_0000;
         msk_q <= 32'h0000_0000;
      end else if (wr_pend_q) begin
         if (wr_addr_q == OFS_CONFIG) cfg_q <= hwdata;
         if (wr_addr_q == OFS_CONTROL) ctl_q <= hwdata;
         if (wr_addr_q == OFS_INT_MASK) msk_q <= hwdata;
      end
   end

   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_halted;
      debug_halt && ctl_q[CTL_STALL_A] && cfg_q[2:0] == CFG_32_TIMER;
   endsequence
   sequence s_unmapped_rd;
      rd_take && haddr >= 12'h050;
   endsequence

   a_ready_high: assert property (hreadyout) // [bus]
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp) // [bus]
      else $error("hresp not OKAY");
   a_reset_quiet: assert property ($rose(hresetn) |-> !timer_irq && !timeout_trigger)
      else $error("event active after reset");
   a_stall_freeze: assert property (s_halted [*4] |-> !timeout_trigger)
      else $error("time-out while stalled");
   a_rdata_hold: assert property (!$past(rd_take) |-> $stable(hrdata)) // [bus]
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (s_unmapped_rd |=> hrdata == ZERO32) // [bus]
      else $error("unmapped read not zero");
   a_irq_masked: assert property (timer_irq |-> (msk_q & 32'h0000_0109) != ZERO32)
      else $error("interrupt without mask bit");
   a_trig_enabled: assert property (timeout_trigger |-> $past(en_a))
      else $error("trigger without enable");
endmodule : gpt_timer_checker

bind gpt_timer gpt_timer_checker gpt_timer_checker_inst (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .capture_pin_even_zero(capture_pin_even_zero), .debug_halt(debug_halt),
   .timeout_trigger(timeout_trigger), .timer_irq(timer_irq));

// ==== test/gpt_rtc_source.sv ====
module gpt_rtc_source (
   // Control
   input wire logic run,
   // Clock out
   output logic clk32k
);
   timeunit 1ns;
   timeprecision 100ps;
   // Fast stand-in for the slow crystal; held low between runs
   always #10 clk32k = run && (clk32k !== 1'b1);
endmodule : gpt_rtc_source

// ==== test/gpt_timer_bench.sv ====
module gpt_timer_bench
   import gpt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = HSIZE_WORD;
   logic [31:0] hwdata = 32'h0000_0000;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic debug_halt = 1'b0;
   logic src_run = 1'b0;
   logic clk32k;
   logic timeout_trigger;
   logic timer_irq;
   int mismatches = 0;
   int check_count = 0;
   int n;
   logic [11:0] ra [11] = '{OFS_CONFIG, OFS_MODE_A, OFS_CONTROL, OFS_INT_MASK, OFS_RAW_STAT,
      OFS_LOAD_A, OFS_COUNT_A, OFS_PRESC_A, OFS_PRESC_B, OFS_MATCH_A, 12'h100};
   logic [31:0] rv [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF,
      32'h0, 32'h0, 32'hFFFF_FFFF, 32'h0};

   assign hready = hreadyout;
   always #4 hclk = ~hclk;

   gpt_timer gpt_timer_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .capture_pin_even_zero(clk32k), .debug_halt(debug_halt),
      .timeout_trigger(timeout_trigger), .timer_irq(timer_irq));
   gpt_rtc_source gpt_rtc_source_inst (.run(src_run), .clk32k(clk32k));

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic ahb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                           output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= HSIZE_WORD;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask : ahb_xfer

   task automatic ahb_wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb_xfer(1'b1, a, d, q);
   endtask : ahb_wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
      logic [31:0] q;
      ahb_xfer(1'b0, a, 32'h0000_0000, q);
      check(name, q, exp);
   endtask : rd_chk

   // Cycles to next trigger, or -1 when none within the limit
   task automatic wait_trig(input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge hclk);
         cnt++;
      end while (timeout_trigger !== 1'b1 && cnt < lim);
      if (timeout_trigger !== 1'b1) cnt = -1;
   endtask : wait_trig

   // ----------------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 11; i++) rd_chk(ra[i], rv[i], "reset value");
      ahb_wr(OFS_CONFIG, 32'h0000_0004);
      ahb_wr(OFS_LOAD_A, 32'h0000_0003);
      ahb_wr(OFS_LOAD_B, 32'h0000_0007);
      ahb_wr(OFS_CONFIG, 32'h0000_0000);
      rd_chk(OFS_LOAD_A, 32'h0007_0003, "joined load");
      ahb_wr(OFS_LOAD_B, 32'h0000_0009);
      rd_chk(OFS_LOAD_A, 32'h0007_0003, "load b in joined mode");
      // Periodic, reloaded while running
      ahb_wr(OFS_MODE_A, {30'h0, MODE_PERIODIC});
      ahb_wr(OFS_MODE_B, {30'h0, MODE_ONE_SHOT});
      ahb_wr(OFS_LOAD_A, 32'h0001_0000);
      rd_chk(OFS_LOAD_B, 32'h0000_0001, "load b upper half");
      rd_chk(OFS_COUNT_A, 32'h0001_0000, "count halves");
      ahb_wr(OFS_CONTROL, 32'h0000_0001);
      ahb_wr(OFS_LOAD_A, 32'h0000_0010);
      wait_trig(40, n);
      check("new load taken", {31'h0, n > 0}, 32'h1);
      wait_trig(40, n);
      check("period", 32'(n), 32'd17);
      rd_chk(OFS_CONTROL, 32'h0000_0001, "periodic enable");
      rd_chk(OFS_RAW_STAT, 32'h0000_0001, "raw time-out");
      rd_chk(OFS_MASK_STAT, 32'h0000_0000, "masked off");
      check("irq masked off", {31'h0, timer_irq}, 32'h0);
      ahb_wr(OFS_INT_MASK, 32'h0000_0001);
      rd_chk(OFS_MASK_STAT, 32'h0000_0001, "masked on");
      check("irq masked on", {31'h0, timer_irq}, 32'h1);
      // Debug stall
      ahb_wr(OFS_CONTROL, 32'h0000_0003);
      debug_halt <= 1'b1;
      repeat (4) @(posedge hclk);
      wait_trig(40, n);
      check("halted", 32'(n), 32'hFFFF_FFFF);
      debug_halt <= 1'b0;
      wait_trig(20, n);
      check("resumed", {31'h0, n > 0}, 32'h1);
      // One-shot
      ahb_wr(OFS_CONTROL, 32'h0000_0000);
      ahb_wr(OFS_MODE_A, {30'h0, MODE_ONE_SHOT});
      ahb_wr(OFS_MODE_B, {30'h0, MODE_PERIODIC});
      ahb_wr(OFS_LOAD_A, 32'h0000_0020);
      ahb_wr(OFS_INT_CLEAR, 32'h0000_0001);
      ahb_wr(OFS_CONTROL, 32'h0000_0001);
      wait_trig(80, n);
      check("one-shot fires", {31'h0, n > 0}, 32'h1);
      repeat (4) @(posedge hclk);
      rd_chk(OFS_CONTROL, 32'h0000_0000, "enable cleared");
      rd_chk(OFS_COUNT_A, 32'h0000_0020, "reloaded count");
      rd_chk(OFS_RAW_STAT, 32'h0000_0001, "flag held");
      ahb_wr(OFS_INT_CLEAR, 32'h0000_0001);
      rd_chk(OFS_RAW_STAT, 32'h0000_0000, "flag cleared");
      check("irq cleared", {31'h0, timer_irq}, 32'h0);
      wait_trig(80, n);
      check("stopped", 32'(n), 32'hFFFF_FFFF);
      // Real-time clock, halted with stall override
      ahb_wr(OFS_CONTROL, 32'h0000_0000);
      ahb_wr(OFS_CONFIG, 32'h0000_0001);
      rd_chk(OFS_COUNT_A, RTC_FIRST, "rtc first load");
      ahb_wr(OFS_MATCH_A, 32'h0000_0005);
      ahb_wr(OFS_INT_MASK, 32'h0000_0008);
      ahb_wr(OFS_CONTROL, 32'h0000_0013);
      debug_halt <= 1'b1;
      src_run <= 1'b1;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (timer_irq !== 1'b1 && n < 90000);
      check("tick span", {31'h0, n >= 81000 && n <= 83000}, 32'h1);
      src_run <= 1'b0;
      debug_halt <= 1'b0;
      rd_chk(OFS_COUNT_A, 32'h0000_0000, "rollover");
      rd_chk(OFS_RAW_STAT, 32'h0000_0008, "rtc raw");
      rd_chk(OFS_MASK_STAT, 32'h0000_0008, "rtc masked");
      ahb_wr(OFS_INT_CLEAR, 32'h0000_0008);
      rd_chk(OFS_RAW_STAT, 32'h0000_0000, "rtc raw clear");
      rd_chk(OFS_MASK_STAT, 32'h0000_0000, "rtc masked clear");
      check("rtc irq clear", {31'h0, timer_irq}, 32'h0);
      final_report();
   end

   // Tests take about 82000 cycles; cut off a little beyond
   initial begin
      #(95000 * 8);
      mismatches++;
      final_report();
   end
endmodule : gpt_timer_bench
